// ---- hw/flsr_pkg.sv ----
// Shared constants and types for the fabric link status and stats responder.
package flsr_pkg;
    // Command codes and response types.
    localparam logic [7:0] CMD_LINK = 8'h38;
    localparam logic [7:0] CMD_STATS = 8'h39;
    localparam logic [7:0] RSP_LINK = 8'hB8;
    localparam logic [7:0] RSP_STATS = 8'hB9;
    localparam logic [15:0] RESP_CODE_OK = 16'h0000;
    localparam logic [15:0] REASON_CODE_OK = 16'h0000;
    // Register byte offsets.
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESP = 8'h40;
    // Command register fields.
    localparam int CMD_CHKERR_BIT = 8;
    localparam int CMD_IDERR_BIT = 9;
    // Status register fields.
    localparam int STS_VALID_BIT = 0;
    localparam int STS_DISCARD_BIT = 1;
    localparam int STS_UNSUP_BIT = 2;
    localparam int STS_TYPE_LSB = 8;
    localparam int STS_LEN_LSB = 16;
    // Response buffer geometry, in 32-bit words after the packet header.
    localparam int RESP_WORDS = 16;
    localparam logic [4:0] LINK_LEN = 5'h03;
    localparam logic [4:0] STATS_LEN = 5'h10;
    localparam int NUM_CTRS = 15;
    localparam int CTR_W = 32;
    localparam logic [31:0] CTR_UNIMPL = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    // Link type and physical state codes.
    localparam logic LINK_ETHERNET = 1'b0;
    localparam logic LINK_FABRIC = 1'b1;
    localparam logic [3:0] PHYS_LINK_UP = 4'h5;
    // AXI responses.
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Live port state as seen by the port training logic.
    typedef struct packed {
        logic linkType;
        logic [3:0] physState;
        logic [3:0] logicalState;
        logic [3:0] activeWidth;
        logic [3:0] supportedWidth;
        logic [7:0] activeSpeed;
        logic [7:0] supportedSpeed;
    } flsr_link_t;
endpackage

// ---- hw/flsr_axil_slave.sv ----
// AXI4-Lite slave front end producing write strobes and read requests.
`timescale 1ns/1ps
module flsr_axil_slave
    import flsr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // AXI4-Lite
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic wrEn,
    output logic [ADDR_W-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrErr,
    output logic [ADDR_W-1:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdErr
);
    logic awHeld_q, wHeld_q, rdPend_q;
    logic awHeld_d, wHeld_d;
    logic [ADDR_W-1:0] awAddr_q, arAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;

    // A write commits once both halves are held and no response is pending.
    assign wrEn = awHeld_q & wHeld_q & ~bvalid;
    assign wrAddr = awAddr_q;
    assign wrData = wData_q;
    assign wrStrb = wStrb_q;
    assign rdAddr = arAddr_q;
    assign awHeld_d = ~wrEn & (awHeld_q | (awvalid & awready));
    assign wHeld_d = ~wrEn & (wHeld_q | (wvalid & wready));

    // Address and data are taken in either order and held until commit.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= AXI_OKAY;
            awAddr_q <= '0;
            wData_q <= WORD_ZERO;
            wStrb_q <= '0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awready <= ~awHeld_d;
            wready <= ~wHeld_d;
            if (awvalid & awready) awAddr_q <= awaddr;
            if (wvalid & wready) begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (wrEn) begin
                bvalid <= 1'b1;
                bresp <= wrErr ? AXI_SLVERR : AXI_OKAY;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // One read at a time; data is sampled the cycle after the address.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            arready <= 1'b0;
            rdPend_q <= 1'b0;
            rvalid <= 1'b0;
            rdata <= WORD_ZERO;
            rresp <= AXI_OKAY;
            arAddr_q <= '0;
        end else begin
            if (arvalid & arready) begin
                arAddr_q <= araddr;
                rdPend_q <= 1'b1;
                arready <= 1'b0;
            end else if (rdPend_q) begin
                rdPend_q <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rdErr ? WORD_ZERO : rdData;
                rresp <= rdErr ? AXI_SLVERR : AXI_OKAY;
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end else if (~rvalid) begin
                arready <= 1'b1;
            end
        end
    end
endmodule

// ---- hw/flsr_stat_counters.sv ----
// Fabric port statistics counters, cleared only by reset.
`timescale 1ns/1ps
module flsr_stat_counters
    import flsr_pkg::*;
#(
    parameter int N = NUM_CTRS,
    parameter logic [NUM_CTRS-1:0] IMPL_MASK = '1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Events and values
    input wire logic [N-1:0] ctrEvent,
    output logic [N-1:0][CTR_W-1:0] ctrVal
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    for (genvar i = 0; i < N; i++) begin : g_ctr
        if (IMPL_MASK[i]) begin : g_impl
            // Wraps like the port counters it mirrors; reads never disturb it.
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    ctrVal[i] <= WORD_ZERO;
                end else if (ctrEvent[i]) begin
                    ctrVal[i] <= ctrVal[i] + 32'h00000001;
                end
            end
            ctr_hold_a: assert property (
                !ctrEvent[i] |=> $stable(ctrVal[i]))
                else $error("Counter moved without an event.");
        end else begin : g_none
            // Absent counters report all ones from the first clock edge on, in reset or not.
            always_ff @(posedge core_clk) begin
                ctrVal[i] <= CTR_UNIMPL;
            end
            ctr_unimpl_a: assert property (
                ##1 ctrVal[i] == CTR_UNIMPL)
                else $error("Absent counter not all ones.");
        end
    end
endmodule

// ---- hw/flsr_top.sv ----
// Responder for the fabric link status and fabric statistics commands.
// Overview of operation
// - Code 0x38 recognised as link status query.
// - Clean link query always gets response 0xB8.
// - Link response: codes, link word, speed word.
// - Supported width for fabric, zero for Ethernet.
// - Link type in bit 0, rest zero.
// - Physical state uses the eight-code encoding.
// - Logical state uses the five-code encoding.
// - Active speed only for fabric link up.
// - Supported speed for fabric, zero for Ethernet.
// - Code 0x39 recognised as statistics query.
// - Clean statistics query always gets response 0xB9.
// - Absent counters report all ones.
// - Counters cleared only by reset.
// - Stats response: codes then fifteen counter words.
`timescale 1ns/1ps
module flsr_top
    import flsr_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter bit FABRIC_CAPABLE = 1'b1,
    parameter logic [NUM_CTRS-1:0] IMPL_MASK = '1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Port state and counter events
    input flsr_link_t linkState,
    input wire logic [NUM_CTRS-1:0] ctrEvent,
    // Response status
    output logic respValid_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    logic wrEn, wrErr, rdErr;
    logic [ADDR_W-1:0] wrAddr, rdAddr;
    logic [31:0] wrData, rdData;
    logic [3:0] wrStrb;
    logic [NUM_CTRS-1:0][CTR_W-1:0] ctrVal;
    logic [RESP_WORDS-1:0][31:0] respBuf_q, respBuf_d;
    logic [7:0] respType_q, lastCmd_q;
    logic [4:0] respLen_q;
    logic discard_q, unsup_q;

    // Register bus front end.
    flsr_axil_slave #(.ADDR_W(ADDR_W)) i_flsr_axil_slave (
        .core_clk(core_clk),
        .srst(srst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrErr(wrErr),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdErr(rdErr)
    );

    // Statistics counters.
    flsr_stat_counters #(.N(NUM_CTRS), .IMPL_MASK(IMPL_MASK))
        i_flsr_stat_counters (
        .core_clk(core_clk),
        .srst(srst),
        .ctrEvent(ctrEvent),
        .ctrVal(ctrVal)
    );

    // Word index of a response-window byte address.
    function automatic logic [ADDR_W-1:0] respIndex(
        input logic [ADDR_W-1:0] addr);
        respIndex = (addr - ADDR_W'(ADDR_RESP)) >> 2;
    endfunction

    // True when a word-aligned address falls inside the response window.
    function automatic logic inResp(input logic [ADDR_W-1:0] addr);
        inResp = (addr >= ADDR_W'(ADDR_RESP))
            && (respIndex(addr) < ADDR_W'(RESP_WORDS))
            && (addr[1:0] == 2'h0);
    endfunction

    // Command decode. Integrity checks are done upstream and flagged here.
    logic cmdWr, cmdChkErr, cmdIdErr, cmdBad, isLinkCmd, isStatsCmd;
    logic linkAccept, statsAccept, anyAccept, cmdDiscard, cmdUnsup;
    logic stsWr;
    assign cmdWr = wrEn & (wrAddr == ADDR_W'(ADDR_CMD)) & wrStrb[0];
    assign stsWr = wrEn & (wrAddr == ADDR_W'(ADDR_STATUS)) & wrStrb[0];
    assign cmdChkErr = wrStrb[1] & wrData[CMD_CHKERR_BIT];
    assign cmdIdErr = wrStrb[1] & wrData[CMD_IDERR_BIT];
    assign cmdBad = cmdChkErr | cmdIdErr;
    assign isLinkCmd = FABRIC_CAPABLE & (wrData[7:0] == CMD_LINK);
    assign isStatsCmd = FABRIC_CAPABLE
        & (wrData[7:0] == CMD_STATS);
    // Commands are framed by the party upstream; only the code is seen.
    assign linkAccept = cmdWr & isLinkCmd & ~cmdBad;
    assign statsAccept = cmdWr & isStatsCmd & ~cmdBad;
    assign anyAccept = linkAccept | statsAccept;
    assign cmdDiscard = cmdWr & (isLinkCmd | isStatsCmd) & cmdBad;
    assign cmdUnsup = cmdWr & ~isLinkCmd & ~isStatsCmd;

    // Link field shaping. Fields that do not apply read zero.
    logic isFabric, physUp;
    logic [7:0] actWidthB, supWidthB, linkTypeB, actSpeedB, supSpeedB;
    logic [3:0] physNib, logNib;
    logic [31:0] linkWord, speedWord, codeWord;
    assign isFabric = linkState.linkType == LINK_FABRIC;
    assign physUp = isFabric & (linkState.physState == PHYS_LINK_UP);
    assign actWidthB = physUp ? {NIB_ZERO, linkState.activeWidth}
                              : BYTE_ZERO;
    assign supWidthB = isFabric ? {NIB_ZERO, linkState.supportedWidth}
                                : BYTE_ZERO;
    assign linkTypeB = {7'h00, linkState.linkType};
    assign physNib = isFabric ? linkState.physState : NIB_ZERO;
    assign logNib = isFabric ? linkState.logicalState : NIB_ZERO;
    assign actSpeedB = physUp ? linkState.activeSpeed
                              : BYTE_ZERO;
    assign supSpeedB = isFabric ? linkState.supportedSpeed
                                : BYTE_ZERO;
    assign codeWord = {RESP_CODE_OK, REASON_CODE_OK};
    assign linkWord = {actWidthB, supWidthB, linkTypeB, physNib, logNib};
    assign speedWord = {BYTE_ZERO, actSpeedB, BYTE_ZERO,
                        supSpeedB};

    // Response image. The whole buffer is rewritten so no stale word leaks.
    always_comb begin
        respBuf_d = respBuf_q;
        if (linkAccept) begin
            respBuf_d = '0;
            respBuf_d[0] = codeWord;
            respBuf_d[1] = linkWord;
            respBuf_d[2] = speedWord;
        end else if (statsAccept) begin
            respBuf_d[0] = codeWord;
            for (int i = 0; i < NUM_CTRS; i++) begin
                respBuf_d[i+1] = ctrVal[i];
            end
        end
    end

    // Response and status state. A new response beats a clear in one cycle.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            respBuf_q <= '0;
            respValid_q <= 1'b0;
            respType_q <= BYTE_ZERO;
            respLen_q <= '0;
            discard_q <= 1'b0;
            unsup_q <= 1'b0;
            lastCmd_q <= BYTE_ZERO;
        end else begin
            respBuf_q <= respBuf_d;
            if (cmdWr) lastCmd_q <= wrData[7:0];
            if (anyAccept) begin
                respValid_q <= 1'b1;
                respType_q <= linkAccept ? RSP_LINK : RSP_STATS;
                respLen_q <= linkAccept ? LINK_LEN : STATS_LEN;
            end else if (stsWr & wrData[STS_VALID_BIT]) begin
                respValid_q <= 1'b0;
            end
            if (cmdDiscard) discard_q <= 1'b1;
            else if (stsWr & wrData[STS_DISCARD_BIT]) discard_q <= 1'b0;
            if (cmdUnsup) unsup_q <= 1'b1;
            else if (stsWr & wrData[STS_UNSUP_BIT]) unsup_q <= 1'b0;
        end
    end

    // Read decode; only the command and status words accept writes.
    logic [31:0] stsWord;
    logic rdIsResp;
    assign stsWord = {11'h000, respLen_q, respType_q, 5'h00, unsup_q,
                      discard_q, respValid_q};
    assign rdIsResp = inResp(rdAddr);
    assign wrErr = (wrAddr != ADDR_W'(ADDR_CMD))
                && (wrAddr != ADDR_W'(ADDR_STATUS));
    assign rdErr = (rdAddr != ADDR_W'(ADDR_CMD))
                && (rdAddr != ADDR_W'(ADDR_STATUS)) && !rdIsResp;
    assign rdData = (rdAddr == ADDR_W'(ADDR_CMD)) ? {24'h000000, lastCmd_q}
                  : (rdAddr == ADDR_W'(ADDR_STATUS)) ? stsWord
                  : rdIsResp ? respBuf_q[respIndex(rdAddr)]
                  : WORD_ZERO;

    // Checks on response generation.
    link_resp_a: assert property (
        linkAccept |=> respValid_q && respType_q == RSP_LINK
            && respLen_q == LINK_LEN)
        else $error("Link query produced no 0xB8 response.");

    stats_resp_a: assert property (
        statsAccept |=> respValid_q && respType_q == RSP_STATS
            && respBuf_q[NUM_CTRS] == $past(ctrVal[NUM_CTRS-1]))
        else $error("Stats query produced no 0xB9 response.");

    discard_cmd_a: assert property (
        cmdDiscard |=> discard_q && $stable(respType_q)
            && $stable(respBuf_q) && respValid_q == $past(respValid_q))
        else $error("Bad query altered the response.");

    code_word_a: assert property (
        anyAccept |=> respBuf_q[0] == codeWord)
        else $error("Response and reason codes wrong.");

    act_width_a: assert property (
        linkAccept && !physUp |=> respBuf_q[1][31:24] == BYTE_ZERO
            && respBuf_q[2][23:16] == BYTE_ZERO)
        else $error("Active field reported while link not up.");

    eth_sup_a: assert property (
        linkAccept && !isFabric |=> respBuf_q[1][23:0] == 24'h000000
            && respBuf_q[2][7:0] == BYTE_ZERO)
        else $error("Ethernet link reported fabric fields.");

    link_type_a: assert property (
        linkAccept |=> respBuf_q[1][15:8]
            == {7'h00, $past(linkState.linkType)})
        else $error("Link type byte wrong.");

    phys_state_a: assert property (
        linkAccept && isFabric |=> respBuf_q[1][7:4]
            == $past(linkState.physState))
        else $error("Physical state nibble wrong.");

    act_speed_a: assert property (
        linkAccept && physUp |=> respBuf_q[2][23:16]
            == $past(linkState.activeSpeed))
        else $error("Active speed not reported while up.");

    resv_zero_a: assert property (
        linkAccept |=> respBuf_q[2][31:24] == BYTE_ZERO
            && respBuf_q[2][15:8] == BYTE_ZERO && respBuf_q[3] == WORD_ZERO)
        else $error("Reserved response bits not zero.");

    // Field checks taken from the live inputs, not from the shaping wires.
    sup_width_a: assert property (
        linkAccept && isFabric |=> respBuf_q[1][23:16]
            == {NIB_ZERO, $past(linkState.supportedWidth)})
        else $error("Supported width byte wrong.");

    eth_state_a: assert property (
        linkAccept && !isFabric |=> respBuf_q[1][7:0] == BYTE_ZERO)
        else $error("Ethernet link reported a state.");

    log_state_a: assert property (
        linkAccept && isFabric |=> respBuf_q[1][3:0]
            == $past(linkState.logicalState))
        else $error("Logical state nibble wrong.");

    sup_speed_a: assert property (
        linkAccept && isFabric |=> respBuf_q[2][7:0]
            == $past(linkState.supportedSpeed))
        else $error("Supported speed byte wrong.");

    stats_first_a: assert property (
        statsAccept |=> respBuf_q[1] == $past(ctrVal[0]))
        else $error("First counter word wrong.");

    resp_hold_a: assert property (
        !anyAccept |=> $stable(respBuf_q))
        else $error("Response image changed without a query.");

    link_cmd_a: assert property (
        cmdWr && !cmdBad && FABRIC_CAPABLE && wrData[7:0] == CMD_LINK
            |=> respType_q == RSP_LINK)
        else $error("Link query code not recognised.");
endmodule

// ---- test/flsr_mgmt_model.sv ----
// Management controller model: an AXI4-Lite master that issues commands.
`timescale 1ns/1ps
module flsr_mgmt_model
    import flsr_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero, with payload lines parked on a junk pattern.
    initial begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'hA5;
        araddr = 8'hA5;
        wdata = 32'hA5A5A5A5;
        wstrb = 4'h0;
    end

    // Write: address and data offered together, each released when taken.
    // Released payload is inverted so a late sample cannot look valid.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge core_clk);
            if (!awDone && awready === 1'b1) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        while (bvalid !== 1'b1) @(posedge core_clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    // Read: address held until taken, rready held until rvalid is seen.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        while (rvalid !== 1'b1) @(posedge core_clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// ---- test/flsr_tb_top.sv ----
// Self-checking testbench for the link status and statistics responder.
`timescale 1ns/1ps
module flsr_tb_top
    import flsr_pkg::*;
;
    localparam logic [14:0] MASK = 15'h3FFF;
    logic core_clk;
    logic srst;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    flsr_link_t linkState;
    logic [14:0] ctrEvent;
    logic respValid_q;
    logic [3:0] lg;
    logic up;
    logic [31:0] rdVal;
    logic [1:0] rdResp;
    int nErrors;
    int cmpCount;

    // The counter at the top of the range is left absent on purpose.
    flsr_top #(.ADDR_W(8), .FABRIC_CAPABLE(1'b1), .IMPL_MASK(MASK))
        i_flsr_top (
        .core_clk(core_clk), .srst(srst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .linkState(linkState), .ctrEvent(ctrEvent),
        .respValid_q(respValid_q));

    flsr_mgmt_model i_flsr_mgmt_model (
        .core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // A 4 ns clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        i_flsr_mgmt_model.rd(a, rdVal, rdResp);
        chkr(rdResp, AXI_OKAY);
        chkv(rdVal & m, e);
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] e);
        logic [1:0] r;
        i_flsr_mgmt_model.wr(a, d, s, r);
        chkr(r, e);
    endtask

    task automatic doReset();
        srst <= 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
    endtask

    // Link query, then the whole body is read back and status cleared.
    task automatic linkChk(input logic [31:0] w1, input logic [31:0] w2);
        wrc(ADDR_CMD, {24'h000000, CMD_LINK}, 4'hF, AXI_OKAY);
        rdc(ADDR_STATUS, 32'hFFFFFFFF,
            {11'h000, LINK_LEN, RSP_LINK, 8'h01});
        chkv({31'h00000000, respValid_q}, 32'h00000001);
        rdc(ADDR_RESP, 32'hFFFFFFFF, 32'h00000000);
        rdc(ADDR_RESP + 8'h04, 32'hFFFFFFFF, w1);
        rdc(ADDR_RESP + 8'h08, 32'hFFFFFFFF, w2);
        rdc(ADDR_RESP + 8'h0C, 32'hFFFFFFFF, 32'h00000000);
        wrc(ADDR_STATUS, 32'h00000007, 4'h1, AXI_OKAY);
    endtask

    // Statistics query; each present counter i expects i+1 events or zero.
    task automatic statsChk(input logic zero);
        wrc(ADDR_CMD, {24'h000000, CMD_STATS}, 4'hF, AXI_OKAY);
        rdc(ADDR_STATUS, 32'hFFFFFFFF,
            {11'h000, STATS_LEN, RSP_STATS, 8'h01});
        rdc(ADDR_RESP, 32'hFFFFFFFF, 32'h00000000);
        for (int i = 0; i < 15; i++) begin
            rdc(ADDR_RESP + 8'(4 * (i + 1)), 32'hFFFFFFFF,
                !MASK[i] ? CTR_UNIMPL :
                (zero ? 32'h00000000 : 32'(i + 1)));
        end
        wrc(ADDR_STATUS, 32'h00000007, 4'h1, AXI_OKAY);
    endtask

    task automatic endSim();
        $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A hang is cut off well beyond the several hundred cycles the run needs.
    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        endSim();
    end

    // Main sequence.
    initial begin
        srst = 1'b1;
        linkState = '0;
        ctrEvent = 15'h0000;
        nErrors = 0;
        cmpCount = 0;
        doReset();
        rdc(ADDR_STATUS, 32'hFFFFFFFF, 32'h00000000);
        // Fabric physical codes 1 to 7, logical codes cycling through 1..4.
        for (int p = 1; p < 8; p++) begin
            lg = 4'((p % 4) + 1);
            up = (p == 5);
            @(posedge core_clk);
            linkState <= '{1'b1, 4'(p), lg, 4'h4, 4'hB, 8'h20, 8'h7F};
            linkChk({up ? 8'h04 : 8'h00, 8'h0B, 8'h01, 4'(p), lg},
                    {8'h00, up ? 8'h20 : 8'h00, 8'h00,
                     8'h7F});
        end
        // Ethernet hides every fabric field even with live inputs behind it.
        @(posedge core_clk);
        linkState <= '{LINK_ETHERNET, PHYS_LINK_UP, 4'h4, 4'h4, 4'hB,
                       8'h20, 8'h7F};
        linkChk(32'h00000000, 32'h00000000);
        // Flagged commands are dropped without a response.
        wrc(ADDR_CMD, {22'h0, 2'b01, CMD_LINK}, 4'h3, AXI_OKAY);
        rdc(ADDR_STATUS, 32'h00000007, 32'h00000002);
        chkv({31'h00000000, respValid_q}, 32'h00000000);
        wrc(ADDR_STATUS, 32'h00000007, 4'h1, AXI_OKAY);
        wrc(ADDR_CMD, {22'h0, 2'b10, CMD_STATS}, 4'h3, AXI_OKAY);
        rdc(ADDR_STATUS, 32'h00000007, 32'h00000002);
        wrc(ADDR_STATUS, 32'h00000007, 4'h1, AXI_OKAY);
        // Unknown code, write without the low byte lane, bad addresses.
        wrc(ADDR_CMD, 32'h00000037, 4'hF, AXI_OKAY);
        rdc(ADDR_STATUS, 32'h00000007, 32'h00000004);
        rdc(ADDR_CMD, 32'h000000FF, 32'h00000037);
        wrc(ADDR_STATUS, 32'h00000007, 4'h1, AXI_OKAY);
        wrc(ADDR_CMD, {24'h000000, CMD_LINK}, 4'h2, AXI_OKAY);
        rdc(ADDR_STATUS, 32'h00000007, 32'h00000000);
        wrc(ADDR_RESP, 32'h00000000, 4'hF, AXI_SLVERR);
        i_flsr_mgmt_model.rd(8'h80, rdVal, rdResp);
        chkr(rdResp, AXI_SLVERR);
        chkv(rdVal, 32'h00000000);
        // Overlapping pulses: counter i sees i+1 events.
        for (int j = 0; j < 15; j++) begin
            @(posedge core_clk);
            ctrEvent <= 15'(15'h7FFF << j);
            @(posedge core_clk);
            ctrEvent <= 15'h0000;
        end
        statsChk(1'b0);
        statsChk(1'b0);
        doReset();
        statsChk(1'b1);
        endSim();
    end
endmodule
